//--- logic/pmd_pkg.sv
package pmd_pkg;
  // ------------------------------------------------------------
  // Register map (word addresses on the byte-addressed port)
  // ------------------------------------------------------------
  localparam logic [7:0] PMD_MODE_OFS = 8'h00;   // Mode and input control
  localparam logic [7:0] PMD_FBINT_OFS = 8'h04;  // Integer feedback ratio
  localparam logic [7:0] PMD_FBFRAC_OFS = 8'h08; // Fraction numerator
  localparam logic [7:0] PMD_OFSLO_OFS = 8'h0C;  // Offset word low 32
  localparam logic [7:0] PMD_OFSHI_OFS = 8'h10;  // Offset word high 8
  localparam logic [7:0] PMD_TRIM_OFS = 8'h14;   // Crystal trim
  localparam logic [7:0] PMD_STAT_OFS = 8'h18;   // Live status
  localparam logic [7:0] PMD_IST_OFS = 8'h1C;    // Sticky events
  localparam logic [7:0] PMD_IMSK_OFS = 8'h20;   // Event mask
  // ------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------
  localparam int PMD_B_PAD = 0;     // Input pad enable
  localparam int PMD_B_OSTART = 1;  // Output startup gate
  localparam int PMD_B_LSEL = 2;    // Lock source select
  localparam int PMD_B_DLOOP = 3;   // Digital loop enable
  localparam int PMD_B_SESEL = 4;   // Single-ended select
  localparam int PMD_B_DBIAS = 5;   // Differential AC bias enable
  localparam int PMD_B_SBIAS = 6;   // Single-ended bias enable
  localparam int PMD_B_DBL = 7;     // Doubler enable
  localparam int PMD_B_RSEL = 8;    // Doubler source select
  localparam int PMD_B_P3 = 9;      // Third pole bypass
  localparam int PMD_B_RNG = 10;    // Lock range field, 3 bits
  localparam int PMD_B_GPIO = 13;   // Route lock to GPIO
  localparam int PMD_MODE_W = 14;
  localparam logic [PMD_MODE_W-1:0] PMD_MODE_RST = 14'h0000;
  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int PMD_INT_W = 9;     // Integer ratio width
  localparam int PMD_FRAC_W = 27;   // Denominator 2^27
  localparam int PMD_OFS_W = 40;    // Offset LSB 2^-40
  localparam int PMD_TRIM_W = 24;   // Trim, same LSB weight
  localparam int PMD_RAT_W = PMD_INT_W + PMD_FRAC_W;
  localparam logic [PMD_INT_W-1:0] PMD_INT_RST = 9'h064;
  localparam logic [PMD_FRAC_W-1:0] PMD_FRAC_RST = 27'h0000000;
  localparam int PMD_EV_W = 2;      // Lock lost, bias done
  // ------------------------------------------------------------
  // Reset sequencer timing
  // ------------------------------------------------------------
  localparam int PMD_CLK_MHZ = 200;
  localparam int PMD_SETTLE_NS = 2000;  // Regulator settle time
  localparam int PMD_STAGE_NS = 100;    // Gap between releases
  localparam int PMD_SETTLE_CYC = (PMD_SETTLE_NS * PMD_CLK_MHZ + 999) / 1000;
  localparam int PMD_STAGE_CYC = (PMD_STAGE_NS * PMD_CLK_MHZ + 999) / 1000;
  localparam int PMD_NBLK = 3;          // Blocks released in order
  localparam int PMD_CNT_W = 12;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    PMD_S_HOLD = 5'b00001,
    PMD_S_SETTLE = 5'b00010,
    PMD_S_BIAS = 5'b00100,
    PMD_S_REL = 5'b01000,
    PMD_S_RUN = 5'b10000
  } pmd_seq_t;
endpackage

//--- logic/pmd_sdm_if.sv
`timescale 1ns/1ps
// Ratio hand-off from control logic to the modulator
interface pmd_sdm_if;
  import pmd_pkg::*;
  logic [PMD_RAT_W-1:0] ratio;        // Integer.fraction setting
  logic step;                         // One per feedback cycle
  logic [PMD_INT_W+1:0] mmd_ratio;    // Instant divider ratio
  modport ctrl (output ratio, output step, input mmd_ratio);
  modport sdm (input ratio, input step, output mmd_ratio);
endinterface

//--- logic/pmd_sdm.sv
`timescale 1ns/1ps
// Second-order MASH modulator steering the divider
module pmd_sdm
(
  input wire logic core_clk_i, // 200 MHz core clock
  input wire logic rst_i,      // Synchronous reset
  pmd_sdm_if.sdm sif           // Ratio in, divider ratio out
);
  import pmd_pkg::*;
  // ------------------------------------------------------------
  // Accumulators
  // ------------------------------------------------------------
  logic [PMD_FRAC_W-1:0] acc1_ff, acc2_ff, nxt_acc1, nxt_acc2;
  logic c2d_ff, nxt_c2d;               // Delayed second carry
  logic [PMD_INT_W+1:0] out_ff, nxt_out;
  logic [PMD_FRAC_W:0] s1, s2;
  // Next state; carries only move on a feedback step
  always_comb
  begin
    s1 = {1'b0, acc1_ff} + {1'b0, sif.ratio[PMD_FRAC_W-1:0]};
    s2 = {1'b0, acc2_ff} + {1'b0, s1[PMD_FRAC_W-1:0]};
    nxt_acc1 = acc1_ff;
    nxt_acc2 = acc2_ff;
    nxt_c2d = c2d_ff;
    nxt_out = out_ff;
    if (sif.step)
    begin
      // Average of int+c1+c2-c2d equals int plus the fraction, noise pushed high
      nxt_acc1 = s1[PMD_FRAC_W-1:0]; // R13
      nxt_acc2 = s2[PMD_FRAC_W-1:0];
      nxt_c2d = s2[PMD_FRAC_W];
      nxt_out = {2'b00, sif.ratio[PMD_RAT_W-1:PMD_FRAC_W]}
        + {{PMD_INT_W+1{1'b0}}, s1[PMD_FRAC_W]}
        + {{PMD_INT_W+1{1'b0}}, s2[PMD_FRAC_W]}
        - {{PMD_INT_W+1{1'b0}}, c2d_ff}; // R12
    end
  end
  // Registers only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      acc1_ff <= '0;
      acc2_ff <= '0;
      c2d_ff <= 1'b0;
      out_ff <= '0;
    end
    else
    begin
      acc1_ff <= nxt_acc1;
      acc2_ff <= nxt_acc2;
      c2d_ff <= nxt_c2d;
      out_ff <= nxt_out;
    end
  end
  assign sif.mmd_ratio = out_ff;
endmodule

//--- logic/pmd_top.sv
`timescale 1ns/1ps
// Overview of operation
// R01 - Offset word scaled by ratio, applied
// R02 - Offset LSB is two to minus forty
// R03 - Offset word ignored in jitter-cleanup mode
// R04 - Separate crystal trim fixed offset
// R05 - Reset gives synth mode; four bits select cleanup
// R06 - Synth mode: digital loop off, inputs unused; dloop_en_o and pad_en_o follow only their own mode bits, whatever the mode
// R07 - Hold reset until regulators settle, ordered release
// R08 - Bias calibration done/fail flags readable
// R09 - Host picks input type and bias
// R10 - Input pad off after reset
// R11 - Doubler enable and its source select
// R12 - Ratio is integer plus fraction over 2^27
// R13 - Modulator switches divider, average equals setting
// R14 - Third pole bypass only for integer ratio
// R15 - Live lock bit readable, optional GPIO
// R16 - Lock falling edge sets sticky flag
// R17 - Host sets lock range for reference
// R18 - Host avoids fractions near 0, 1, 1/2
// R19 - Write one clears; new edge wins
module pmd_top
(
  input wire logic core_clk_i,                // 200 MHz clock
  input wire logic rst_i,                     // Sync reset, high
  input wire logic [7:0] addr_i,              // Register byte address
  input wire logic [31:0] wdata_i,            // Write data
  input wire logic wr_i,                      // Write strobe
  input wire logic rd_i,                      // Read strobe
  output logic [31:0] rdata_o,                // Read data, next cycle
  output logic irq_o,                         // Level interrupt
  input wire logic reg_ok_i,                  // Regulators stable pin
  input wire logic bias_done_i,               // Bias cal finished pin
  input wire logic bias_fail_i,               // Bias cal error pin
  input wire logic apll_lock_i,               // Analog lock pin
  input wire logic fb_tick_i,                 // Feedback divider clock
  output logic bias_start_o,                  // Starts bias calibration
  output logic [pmd_pkg::PMD_NBLK-1:0] blk_rst_o, // Block resets
  output logic pad_en_o,                      // Reference pad enable
  output logic single_ended_o,                // Single-ended input
  output logic diff_ac_bias_o,                // Differential AC bias
  output logic se_ac_bias_o,                  // Single-ended AC bias
  output logic doubler_en_o,                  // Doubler on
  output logic doubler_src_o,                 // 0 crystal, 1 reference
  output logic third_pole_bypass_o,           // Loop filter bypass
  output logic [2:0] lock_range_o,            // Lock detector range
  output logic dloop_en_o,                    // Digital loop power
  output logic gpio_lock_o,                   // Lock state on GPIO
  output logic [pmd_pkg::PMD_INT_W+1:0] mmd_ratio_o // Divider ratio
);
  import pmd_pkg::*;
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] s1_ff, s2_ff;  // Two-stage pin sync
  logic lock_d_ff, tick_d_ff; // Edge detect history
  logic reg_ok_s, bdone_s, bfail_s, lock_s, tick_s;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      lock_d_ff <= 1'b0;
      tick_d_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= {fb_tick_i, apll_lock_i, bias_fail_i, bias_done_i, reg_ok_i};
      s2_ff <= s1_ff;
      lock_d_ff <= s2_ff[3];
      tick_d_ff <= s2_ff[4];
    end
  end
  assign {tick_s, lock_s, bfail_s, bdone_s, reg_ok_s} = s2_ff;
  logic lock_fall, tick_rise;
  assign lock_fall = lock_d_ff & ~lock_s; // R16
  assign tick_rise = tick_s & ~tick_d_ff;
  // ------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------
  pmd_seq_t st_ff, nxt_st;
  logic [PMD_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [PMD_NBLK-1:0] brst_ff, nxt_brst;
  logic cal_done_ff, nxt_cal_done, cal_fail_ff, nxt_cal_fail;
  logic bstart_ff, nxt_bstart;
  // Waits for regulators, calibrates bias, releases blocks in order
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_brst = brst_ff;
    nxt_cal_done = cal_done_ff;
    nxt_cal_fail = cal_fail_ff;
    nxt_bstart = 1'b0;
    case (st_ff)
      PMD_S_HOLD:
      begin
        // Everything held until regulators report good
        nxt_brst = '1; // R07
        nxt_cnt = '0;
        if (reg_ok_s)
          nxt_st = PMD_S_SETTLE;
      end
      PMD_S_SETTLE:
      begin
        // Debounce window; a dropout restarts the wait
        if (!reg_ok_s)
          nxt_st = PMD_S_HOLD;
        else if (cnt_ff == PMD_CNT_W'(PMD_SETTLE_CYC - 1))
        begin
          nxt_st = PMD_S_BIAS;
          nxt_cnt = '0;
          nxt_bstart = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      PMD_S_BIAS:
      begin
        // Failure is flagged but startup still goes on
        if (bfail_s)
        begin
          nxt_cal_fail = 1'b1; // R08
          nxt_st = PMD_S_REL;
        end
        else if (bdone_s)
        begin
          nxt_cal_done = 1'b1; // R08
          nxt_st = PMD_S_REL;
        end
      end
      PMD_S_REL:
      begin
        // One block out of reset per stage gap, lowest first
        if (cnt_ff == PMD_CNT_W'(PMD_STAGE_CYC - 1))
        begin
          nxt_cnt = '0;
          nxt_brst = {brst_ff[PMD_NBLK-1:1], 1'b0} << 1; // R07
          nxt_brst[0] = 1'b0;
          if (brst_ff[PMD_NBLK-1:1] == '0)
            nxt_st = PMD_S_RUN;
        end
        else
          nxt_cnt = cnt_ff + 1'b1;
        if (brst_ff[0])
        begin
          // Restart the gap so every later stage waits a full gap
          nxt_brst = {brst_ff[PMD_NBLK-1:1], 1'b0};
          nxt_cnt = '0;
        end
      end
      PMD_S_RUN:
        nxt_brst = '0;
      default:
        nxt_st = PMD_S_HOLD;
    endcase
  end
  // Sequencer registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= PMD_S_HOLD;
      cnt_ff <= '0;
      brst_ff <= '1;
      cal_done_ff <= 1'b0;
      cal_fail_ff <= 1'b0;
      bstart_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      brst_ff <= nxt_brst;
      cal_done_ff <= nxt_cal_done;
      cal_fail_ff <= nxt_cal_fail;
      bstart_ff <= nxt_bstart;
    end
  end
  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [PMD_MODE_W-1:0] mode_ff, nxt_mode;
  logic [PMD_INT_W-1:0] int_ff, nxt_int;
  logic [PMD_FRAC_W-1:0] frac_ff, nxt_frac;
  logic [PMD_OFS_W-1:0] ofs_ff, nxt_ofs;
  logic [PMD_TRIM_W-1:0] trim_ff, nxt_trim;
  logic [PMD_EV_W-1:0] ist_ff, nxt_ist, imsk_ff, nxt_imsk, ev;
  logic [31:0] rdata_ff, nxt_rdata;
  logic cal_done_d_ff;
  logic jit_mode;
  // Cleanup mode needs all four mode bits set
  assign jit_mode = mode_ff[PMD_B_PAD] & mode_ff[PMD_B_OSTART]
    & mode_ff[PMD_B_LSEL] & mode_ff[PMD_B_DLOOP]; // R05
  assign ev = {cal_done_ff & ~cal_done_d_ff, lock_fall};
  // Writes, sticky events and read mux
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_int = int_ff;
    nxt_frac = frac_ff;
    nxt_ofs = ofs_ff;
    nxt_trim = trim_ff;
    nxt_imsk = imsk_ff;
    nxt_rdata = 32'h00000000;
    nxt_ist = ist_ff;
    if (wr_i)
    begin
      case (addr_i)
        PMD_MODE_OFS: nxt_mode = wdata_i[PMD_MODE_W-1:0];
        PMD_FBINT_OFS: nxt_int = wdata_i[PMD_INT_W-1:0];
        PMD_FBFRAC_OFS: nxt_frac = wdata_i[PMD_FRAC_W-1:0]; // R12
        PMD_OFSLO_OFS: nxt_ofs[31:0] = wdata_i;
        PMD_OFSHI_OFS: nxt_ofs[PMD_OFS_W-1:32] = wdata_i[7:0];
        PMD_TRIM_OFS: nxt_trim = wdata_i[PMD_TRIM_W-1:0]; // R04
        PMD_IST_OFS: nxt_ist = ist_ff & ~wdata_i[PMD_EV_W-1:0]; // R19
        PMD_IMSK_OFS: nxt_imsk = wdata_i[PMD_EV_W-1:0];
        default: nxt_mode = mode_ff;
      endcase
    end
    // A new event in the clear cycle stays set
    nxt_ist = nxt_ist | ev; // R16 R19
    if (rd_i)
    begin
      case (addr_i)
        PMD_MODE_OFS: nxt_rdata[PMD_MODE_W-1:0] = mode_ff;
        PMD_FBINT_OFS: nxt_rdata[PMD_INT_W-1:0] = int_ff;
        PMD_FBFRAC_OFS: nxt_rdata[PMD_FRAC_W-1:0] = frac_ff;
        PMD_OFSLO_OFS: nxt_rdata = ofs_ff[31:0];
        PMD_OFSHI_OFS: nxt_rdata[7:0] = ofs_ff[PMD_OFS_W-1:32];
        PMD_TRIM_OFS: nxt_rdata[PMD_TRIM_W-1:0] = trim_ff;
        PMD_STAT_OFS: nxt_rdata[4:0] = {st_ff == PMD_S_RUN, jit_mode,
          cal_fail_ff, cal_done_ff, lock_s}; // R08 R15
        PMD_IST_OFS: nxt_rdata[PMD_EV_W-1:0] = ist_ff;
        PMD_IMSK_OFS: nxt_rdata[PMD_EV_W-1:0] = imsk_ff;
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end
  // Register bank; defaults give synth mode with pad off
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= PMD_MODE_RST; // R05 R10
      int_ff <= PMD_INT_RST;
      frac_ff <= PMD_FRAC_RST;
      ofs_ff <= '0;
      trim_ff <= '0;
      ist_ff <= '0;
      imsk_ff <= '0;
      rdata_ff <= 32'h00000000;
      cal_done_d_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      int_ff <= nxt_int;
      frac_ff <= nxt_frac;
      ofs_ff <= nxt_ofs;
      trim_ff <= nxt_trim;
      ist_ff <= nxt_ist;
      imsk_ff <= nxt_imsk;
      rdata_ff <= nxt_rdata;
      cal_done_d_ff <= cal_done_ff;
    end
  end
  // ------------------------------------------------------------
  // Ratio with scaled offset
  // ------------------------------------------------------------
  logic [PMD_RAT_W-1:0] ratio_q, eff_ff, nxt_eff;
  logic signed [PMD_OFS_W:0] tot_ofs;
  logic signed [PMD_RAT_W+PMD_OFS_W+1:0] prod;
  assign ratio_q = {int_ff, frac_ff};
  // Offset word dropped in cleanup mode; trim always applies
  always_comb
  begin
    tot_ofs = (PMD_OFS_W+1)'(signed'(trim_ff)); // R04
    if (!jit_mode)
      tot_ofs = tot_ofs + (PMD_OFS_W+1)'(signed'(ofs_ff)); // R03
    // LSB 2^-40 of the ratio, so shift 40 back to 2^-27 units
    prod = signed'({1'b0, ratio_q}) * tot_ofs; // R01 R02
    nxt_eff = ratio_q + PMD_RAT_W'(prod >>> PMD_OFS_W); // R01
  end
  // Pipeline register keeps the wide product off the loop path
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      eff_ff <= {PMD_INT_RST, PMD_FRAC_RST};
    else
      eff_ff <= nxt_eff;
  end
  pmd_sdm_if sif ();
  assign sif.ratio = eff_ff;
  assign sif.step = tick_rise;
  pmd_sdm u_sdm
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sif(sif)
  );
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata_o = rdata_ff;
  assign irq_o = |(ist_ff & imsk_ff);
  assign bias_start_o = bstart_ff;
  assign blk_rst_o = brst_ff;
  assign pad_en_o = mode_ff[PMD_B_PAD]; // R10
  assign single_ended_o = mode_ff[PMD_B_SESEL];
  assign diff_ac_bias_o = mode_ff[PMD_B_DBIAS];
  assign se_ac_bias_o = mode_ff[PMD_B_SBIAS];
  assign doubler_en_o = mode_ff[PMD_B_DBL]; // R11
  assign doubler_src_o = mode_ff[PMD_B_RSEL]; // R11
  // Bypass only honoured for an integer ratio, protects the loop
  assign third_pole_bypass_o = mode_ff[PMD_B_P3] & (frac_ff == '0); // R14
  assign lock_range_o = mode_ff[PMD_B_RNG+2:PMD_B_RNG];
  assign dloop_en_o = mode_ff[PMD_B_DLOOP]; // R06
  assign gpio_lock_o = mode_ff[PMD_B_GPIO] & lock_s; // R15
  assign mmd_ratio_o = sif.mmd_ratio; // R13
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_lol_sets_flag: assert property (lock_fall |=> ist_ff[0]) // R16
    else $error("lock loss did not set flag");
  a_set_beats_clear: assert property (ist_ff[0] && wr_i // R19
    && addr_i == PMD_IST_OFS && wdata_i[0] && lock_fall |=> ist_ff[0])
    else $error("clear beat new lock loss");
  a_zero_keeps_flag: assert property (ist_ff[0] && wr_i // R19
    && addr_i == PMD_IST_OFS && !wdata_i[0] |=> ist_ff[0])
    else $error("writing zero cleared flag");
  a_jit_no_offset: assert property (jit_mode && trim_ff == '0 // R03
    |=> eff_ff == $past(ratio_q))
    else $error("offset applied in cleanup mode");
  a_reset_synth_mode: assert property ($past(rst_i) |-> !jit_mode // R05
    && !pad_en_o) else $error("reset mode not synth");
  a_hold_in_reset: assert property (st_ff == PMD_S_HOLD // R07
    |=> blk_rst_o == '1) else $error("blocks left hold early");
  a_release_order: assert property ($fell(blk_rst_o[1]) // R07
    |-> !blk_rst_o[0]) else $error("release out of order");
  a_fail_continues: assert property (st_ff == PMD_S_BIAS // R08
    && bfail_s |=> cal_fail_ff && st_ff == PMD_S_REL)
    else $error("bias fail stalled startup");
  a_status_read: assert property (rd_i && addr_i == PMD_STAT_OFS // R08
    |=> rdata_o[2:1] == $past({cal_fail_ff, cal_done_ff}))
    else $error("status read wrong");
  c_lock_lost: cover property (lock_fall ##1 irq_o);
  c_jit_mode: cover property ($rose(jit_mode));
  c_run: cover property (st_ff == PMD_S_RUN);
endmodule

//--- bench/pmd_ana_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog side stand-in: regulators, bias cal, lock, divider
// ------------------------------------------------------------
module pmd_ana_model
(
  input wire logic core_clk_i,   // 200 MHz core clock
  input wire logic rst_i,        // Sync reset, high
  input wire logic bias_start_i, // Calibration kick
  input wire logic lock_req_i,   // Lock state the bench wants
  input wire logic fail_req_i,   // Next calibration fails
  output logic reg_ok_o,         // Regulators stable
  output logic bias_done_o,      // Calibration finished
  output logic bias_fail_o,      // Calibration error on request
  output logic apll_lock_o,      // Analog lock state
  output logic fb_tick_o         // Feedback clock, period 8 cycles
);
  logic [7:0] cnt_ff; // Free running cycle count
  logic [3:0] cal_ff; // Calibration countdown
  logic up_ff; // Regulators have come up
  // Regulators settle a few cycles after reset, then stay up
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 8'h00;
      cal_ff <= 4'h0;
      bias_done_o <= 1'b0;
      bias_fail_o <= 1'b0;
      up_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 8'h01;
      // Calibration takes ten cycles from the kick
      if (bias_start_i)
        cal_ff <= 4'hA;
      else if (cal_ff != 4'h0)
        cal_ff <= cal_ff - 4'h1;
      if (cal_ff == 4'h1)
      begin
        bias_done_o <= !fail_req_i;
        bias_fail_o <= fail_req_i;
      end
      if (cnt_ff == 8'h04)
        up_ff <= 1'b1;
    end
  end
  // Low during reset so the hold-off is really exercised
  // Latched, so the wrapping count can never drop it again
  assign reg_ok_o = up_ff;
  assign apll_lock_o = lock_req_i;
  // Divider clock runs free; pins are synced inside the block
  assign fb_tick_o = cnt_ff[2];
endmodule

//--- bench/test_pll_mode_and_dco_control.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the mode and oscillator control
// ------------------------------------------------------------
module test_pll_mode_and_dco_control;
  import pmd_pkg::*;
  logic core_clk_i = 1'b0; // 200 MHz clock
  logic rst_i = 1'b1; // Sync reset
  logic [7:0] addr_i = 8'h00; // Bus address
  logic [31:0] wdata_i = 32'h0; // Bus write data
  logic wr_i = 1'b0; // Write strobe
  logic rd_i = 1'b0; // Read strobe
  logic lock_req = 1'b0; // Commanded lock state
  logic fail_req = 1'b0; // Makes the next calibration fail
  logic reg_ok, bias_done, bias_fail, apll_lock, fb_tick, bias_start;
  logic [31:0] rdata, d;
  logic irq, pad_en, se, dbias, sbias, dbl, dsrc, p3, dloop, gpio;
  logic [2:0] blk_rst, rng;
  logic [PMD_INT_W+1:0] div_ratio;
  logic [13:0] obs; // Mode pins packed as in the mode register
  int num_errors = 0;
  int tests_run = 0;
  int n, sum;
  assign obs = {gpio, rng, p3, dsrc, dbl, sbias, dbias, se, dloop,
                2'b00, pad_en};
  always #2.5 core_clk_i = ~core_clk_i;
  pmd_top pmd_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .irq_o(irq), .reg_ok_i(reg_ok),
    .bias_done_i(bias_done), .bias_fail_i(bias_fail),
    .apll_lock_i(apll_lock), .fb_tick_i(fb_tick),
    .bias_start_o(bias_start), .blk_rst_o(blk_rst), .pad_en_o(pad_en),
    .single_ended_o(se), .diff_ac_bias_o(dbias), .se_ac_bias_o(sbias),
    .doubler_en_o(dbl), .doubler_src_o(dsrc), .third_pole_bypass_o(p3),
    .lock_range_o(rng), .dloop_en_o(dloop), .gpio_lock_o(gpio),
    .mmd_ratio_o(div_ratio));
  pmd_ana_model pmd_ana_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .bias_start_i(bias_start), .lock_req_i(lock_req),
    .fail_req_i(fail_req), .reg_ok_o(reg_ok),
    .bias_done_o(bias_done), .bias_fail_o(bias_fail),
    .apll_lock_o(apll_lock), .fb_tick_o(fb_tick));
  // ------------------------------------------------------------
  // Compare, report and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int got);
    tests_run++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and ends the run
  task automatic timeout(input string nm);
    num_errors++;
    $display("mismatch %s expected event seen timeout", nm);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_startup();
    n = 0;
    chk("blk_rst_hold", 32'h7, {29'h0, blk_rst});
    while (bias_start !== 1'b1)
    begin
      tick(1);
      n++;
      if (n > 2000) timeout("bias_start");
    end
    chk_rng("settle_cycles", 400, 600, n);
    chk("blk_rst_cal", 32'h7, {29'h0, blk_rst});
    n = 0;
    while (blk_rst[0] !== 1'b0)
    begin
      tick(1);
      n++;
      if (n > 200) timeout("blk_rst0");
    end
    chk("blk_rst_first", 32'h6, {29'h0, blk_rst});
    n = 0;
    while (blk_rst !== 3'b000)
    begin
      tick(1);
      n++;
      if (n > 200) timeout("blk_rst_all");
    end
    chk("release_gap", 32'd40, 32'(n));
    // Run state follows one more gap after the last release
    tick(PMD_STAGE_CYC);
    rd(PMD_STAT_OFS, d);
    chk("status_run", 32'h12, d);
    chk("pins_reset", 32'h0, {18'h0, obs});
    rd(PMD_FBINT_OFS, d);
    chk("int_reset", {23'h0, PMD_INT_RST}, d);
    rd(PMD_FBFRAC_OFS, d);
    chk("frac_reset", 32'h0, d);
  endtask
  // Every mode bit on its own, then the four cleanup bits together
  task automatic t_mode();
    for (int i = 0; i < 14; i++)
    begin
      wr(PMD_MODE_OFS, 32'h1 << i);
      rd(PMD_MODE_OFS, d);
      chk("mode_rb", 32'h1 << i, d);
      chk("mode_pins", (32'h1 << i) & 32'h1FF9, {18'h0, obs});
    end
    wr(PMD_MODE_OFS, 32'hF);
    rd(PMD_STAT_OFS, d);
    chk("status_cleanup", 32'h1A, d);
    wr(PMD_FBFRAC_OFS, 32'h1);
    wr(PMD_MODE_OFS, 32'h200);
    tick(2);
    chk("p3_fraction", 32'h0, {31'h0, p3});
    wr(PMD_FBFRAC_OFS, 32'h0);
    tick(2);
    chk("p3_integer", 32'h1, {31'h0, p3});
  endtask
  // Offset of a quarter turns ratio 8 into 10, not in cleanup
  task automatic t_offset();
    wr(PMD_FBINT_OFS, 32'h8);
    wr(PMD_OFSHI_OFS, 32'h40);
    wr(PMD_OFSLO_OFS, 32'h0);
    wr(PMD_MODE_OFS, 32'h0);
    tick(100);
    chk("ratio_offset", 32'd10, {21'h0, div_ratio});
    wr(PMD_MODE_OFS, 32'hF);
    tick(100);
    chk("ratio_cleanup", 32'd8, {21'h0, div_ratio});
    wr(PMD_OFSHI_OFS, 32'h0);
    wr(PMD_MODE_OFS, 32'h0);
  endtask
  // Average of the divider ratio over 64 feedback ticks
  task automatic t_fraction();
    wr(PMD_FBFRAC_OFS, 32'h2000000);
    tick(100);
    sum = 0;
    for (int i = 0; i < 64; i++)
    begin
      sum += int'(div_ratio);
      tick(8);
    end
    chk_rng("ratio_average", 524, 532, sum);
    wr(PMD_FBFRAC_OFS, 32'h0);
  endtask
  task automatic t_sticky();
    wr(PMD_IMSK_OFS, 32'h1);
    wr(PMD_MODE_OFS, 32'h2000);
    lock_req <= 1'b1;
    tick(20);
    chk("gpio_locked", 32'h1, {31'h0, gpio});
    rd(PMD_STAT_OFS, d);
    chk("status_lock", 32'h13, d);
    chk("irq_quiet", 32'h0, {31'h0, irq});
    lock_req <= 1'b0;
    tick(20);
    chk("gpio_lost", 32'h0, {31'h0, gpio});
    rd(PMD_IST_OFS, d);
    chk("sticky_set", 32'h3, d);
    chk("irq_lost", 32'h1, {31'h0, irq});
    wr(PMD_IST_OFS, 32'h0);
    rd(PMD_IST_OFS, d);
    chk("sticky_keep", 32'h3, d);
    wr(PMD_IST_OFS, 32'h1);
    rd(PMD_IST_OFS, d);
    chk("sticky_clear", 32'h2, d);
    chk("irq_clear", 32'h0, {31'h0, irq});
    wr(PMD_IMSK_OFS, 32'h2);
    tick(2);
    chk("irq_bias", 32'h1, {31'h0, irq});
    wr(PMD_IST_OFS, 32'h2);
    tick(2);
    chk("irq_none", 32'h0, {31'h0, irq});
  endtask
  // Read data stands one cycle; unmapped reads give zero
  task automatic t_bus();
    rd(PMD_STAT_OFS, d);
    tick(1);
    chk("rdata_drop", 32'h0, rdata);
    rd(8'h40, d);
    chk("unmapped", 32'h0, d);
  endtask
  // Mid-run reset with a failing calibration; startup still goes on
  task automatic t_fail();
    rst_i <= 1'b1;
    fail_req <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    n = 0;
    while (blk_rst[0] !== 1'b0)
    begin
      tick(1);
      n++;
      if (n > 2000) timeout("fail_release");
    end
    rd(PMD_STAT_OFS, d);
    chk("status_fail", 32'h4, d);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    tick(1);
    t_startup();
    t_mode();
    t_offset();
    t_fraction();
    t_sticky();
    t_bus();
    t_fail();
    results();
  end
endmodule
